/* File: logic/cod_decode_timing.sv */
// Purpose: opcode fetch, decode and machine-cycle timing of the controller core
// Assumes: code_data returns the byte at code_addr in the same clock (async rom)
// Notes:   one instruction spans tbl_cyc machine cycles of its_field+1 clocks
//
// Contract
// - opcodes keep the standard 8-bit controller encoding and effect.
// - 28-2F add register to accumulator, one byte, one cycle.
// - 26-27 indirect add one byte, 24 immediate add two bytes, both two cycles.
// - 38-3F add with carry register one/one; 35 direct two/two.
// - 98-9F subtract one cycle; 95, 96-97, 94 take two cycles.
// - 53 ands immediate into direct byte, three bytes, four cycles.
// - 68-6F xor register into accumulator, one byte, one cycle.
// - 33 rotate left through carry, 13 rotate right, one byte each.
// - A8-AF move direct byte to register, two bytes, four cycles.
// - A6-A7 move direct byte to indirect ram, two bytes, five cycles.
// - 90 loads the data pointer pair, three bytes, three cycles.
// - 83 and 93 code reads into accumulator, one byte, three cycles.
// - E2-E3 and E0 external reads take three cycles.
// - F2-F3 and F0 external writes take four cycles.
// - C0 push four cycles, D0 pop three cycles, two bytes each.
// - 60 branch if zero, 70 if nonzero, two bytes, three cycles.
// - 40 branch on carry, 50 on no carry, two bytes, three cycles.
// - 10 branches on set bit and clears it, three bytes, four cycles.
// - B5, B4, B8-BF compare and branch, three bytes, four cycles.
// - D8-DF decrement branch two/three; D5 three bytes, four cycles.
// - B0 and A0 use inverted bit into carry, two bytes, two cycles.
// - 92 carry to bit three cycles; A2 bit to carry two cycles.
// - machine cycle is one to eight clocks, two after reset.
// - stack pointer resets to 07h, increments before a push stores.
`timescale 1ns/100ps
`include "cod_regs.svh"

module cod_decode_timing (
  input  wire logic          core_clk,
  input  wire logic          srst,
  input  wire logic [7:0]    code_data,
  output logic      [15:0]   code_addr,
  output logic               code_rd,
  input  wire logic          clk_ctl_wr,
  input  wire logic [2:0]    clk_ctl_its,
  output logic      [7:0]    opcode,
  output logic      [7:0]    operand1,
  output logic      [7:0]    operand2,
  output cod_pkg::cod_len_t  instr_len,
  output cod_pkg::cod_cyc_t  instr_cycles,
  output logic               instr_done,
  output logic               mc_end,
  output logic      [15:0]   pc,
  output logic      [7:0]    sp,
  output logic      [15:0]   data_pointer_pair,
  output logic               stack_wr,
  output logic      [7:0]    stack_addr
);

  cod_pkg::cod_state_t state;
  cod_pkg::cod_len_t   tbl_len;
  cod_pkg::cod_cyc_t   tbl_cyc;
  logic [2:0]          its_field;
  logic [2:0]          div;
  logic [2:0]          mc_cnt;
  logic [1:0]          step;
  logic                run;
  logic                mc_last;
  logic                last_clk;
  logic                tbl_load;
  logic [15:0]         pc_next;
  logic [2:0]          fetch_ofs;
  logic [15:0]         next_code_addr;
  logic [`COD_CNT_W-1:0] clk_cnt;
  logic                its_stable;

  // opcode lookup; loaded on the last clock so it is valid from the first
  cod_op_table u_table (
    .core_clk  (core_clk),
    .srst      (srst),
    .load      (tbl_load),
    .opcode_in (code_data),
    .tbl_len   (tbl_len),
    .tbl_cyc   (tbl_cyc)
  );

  // decode of where in the instruction we stand
  assign run      = (state == cod_pkg::COD_RUN);
  assign mc_last  = run && (div >= its_field);
  assign last_clk = mc_last && (mc_cnt == tbl_cyc - 3'h1);
  assign tbl_load = (state == cod_pkg::COD_BOOT && code_rd) || last_clk;
  assign pc_next  = pc + {14'h0000, tbl_len};

  // next fetch offset is min(step+2, len): operands in order, then next opcode
  always_comb begin
    fetch_ofs = {1'b0, step} + 3'h2;
    if (fetch_ofs > {1'b0, tbl_len}) begin
      fetch_ofs = {1'b0, tbl_len};
    end
    if (state == cod_pkg::COD_BOOT) begin
      next_code_addr = code_rd ? code_addr + 16'h0001 : `COD_PC_RESET;
    end else if (last_clk) begin
      next_code_addr = pc_next + 16'h0001;
    end else begin
      next_code_addr = pc + {13'h0000, fetch_ofs};
    end
  end

  // boot waits one clock for the read strobe, then runs for good
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= cod_pkg::COD_BOOT;
    end else begin
      case (state)
        cod_pkg::COD_BOOT: begin
          if (code_rd) begin
            state <= cod_pkg::COD_RUN;
          end
        end
        cod_pkg::COD_RUN: begin
          state <= cod_pkg::COD_RUN;
        end
        default: begin
          state <= cod_pkg::COD_BOOT;
        end
      endcase
    end
  end

  // program memory strobe and address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      code_rd   <= 1'b0;
      code_addr <= `COD_PC_RESET;
    end else begin
      code_rd   <= 1'b1;
      code_addr <= next_code_addr;
    end
  end

  // program counter steps by the whole length when the instruction retires
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc <= `COD_PC_RESET;
    end else if (last_clk) begin
      pc <= pc_next;
    end
  end

  // timing select; may change any time, takes effect at the mc_last compare above
  always_ff @(posedge core_clk) begin
    if (srst) begin
      its_field <= `COD_ITS_RESET;
    end else if (clk_ctl_wr) begin
      its_field <= clk_ctl_its;
    end
  end

  // clock divider and machine-cycle count; >= so a lowered select ends early
  always_ff @(posedge core_clk) begin
    if (srst || tbl_load) begin
      div    <= 3'h0;
      mc_cnt <= 3'h0;
    end else if (mc_last) begin
      div    <= 3'h0;
      mc_cnt <= mc_cnt + 3'h1;
    end else if (run) begin
      div    <= div + 3'h1;
    end
  end

  // clock index inside the instruction, saturating
  always_ff @(posedge core_clk) begin
    if (srst || tbl_load) begin
      step <= 2'h0;
    end else if (step != 2'h3) begin
      step <= step + 2'h1;
    end
  end

  // opcode byte kept alongside the table result
  always_ff @(posedge core_clk) begin
    if (srst) begin
      opcode <= 8'h00;
    end else if (tbl_load) begin
      opcode <= code_data;
    end
  end

  // operands arrive on clocks 0 and 1 of the instruction
  always_ff @(posedge core_clk) begin
    if (srst) begin
      operand1 <= 8'h00;
      operand2 <= 8'h00;
    end else if (run && !last_clk) begin
      if (step == 2'h0 && tbl_len >= 2'h2) begin
        operand1 <= code_data;
      end
      if (step == 2'h1 && tbl_len == 2'h3) begin
        operand2 <= code_data;
      end
    end
  end

  // retire strobe and machine-cycle strobe, one clock late from flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      instr_done   <= 1'b0;
      mc_end       <= 1'b0;
      instr_len    <= 2'h1;
      instr_cycles <= 3'h1;
    end else begin
      instr_done <= last_clk;
      mc_end     <= mc_last;
      if (last_clk) begin
        instr_len    <= tbl_len;
        instr_cycles <= tbl_cyc;
      end
    end
  end

  // stack pointer: pre-increment on push, post-decrement when a pop retires
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp <= `COD_SP_RESET;
    end else if (run && step == 2'h0 && opcode == `COD_OP_PUSH) begin
      sp <= sp + 8'h01;
    end else if (last_clk && opcode == `COD_OP_POP) begin
      sp <= sp - 8'h01;
    end
  end

  // push store strobe uses the already incremented pointer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stack_wr   <= 1'b0;
      stack_addr <= `COD_SP_RESET;
    end else begin
      stack_wr <= last_clk && opcode == `COD_OP_PUSH;
      if (last_clk && opcode == `COD_OP_PUSH) begin
        stack_addr <= sp;
      end
    end
  end

  // data pointer pair: high byte comes first in the instruction stream
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_pointer_pair <= 16'h0000;
    end else if (last_clk && opcode == `COD_OP_DPP_LOAD) begin
      data_pointer_pair <= {operand1, operand2};
    end
  end

  // helper for checks: clocks spent and whether the select held still
  always_ff @(posedge core_clk) begin
    if (srst || tbl_load) begin
      clk_cnt    <= 6'h01;
      its_stable <= 1'b1;
    end else begin
      clk_cnt <= clk_cnt + 6'h01;
      if (clk_ctl_wr) begin
        its_stable <= 1'b0;
      end
    end
  end

  sequence s_push_first;
    run && step == 2'h0 && opcode == `COD_OP_PUSH;
  endsequence

  sequence s_retire;
    last_clk ##1 instr_done;
  endsequence

  property p_row(logic [7:0] lo, logic [7:0] hi, logic [1:0] l, logic [2:0] c);
    @(posedge core_clk) disable iff (srst)
      tbl_load && code_data >= lo && code_data <= hi |=> tbl_len == l && tbl_cyc == c;
  endproperty

  a_add_reg_row: assert property (p_row(8'h28, 8'h2F, 2'h1, 3'h1))
    else $error("add register row wrong");
  a_add_imm_row: assert property (p_row(8'h24, 8'h24, 2'h2, 3'h2))
    else $error("add immediate row wrong");
  a_and_direct_row: assert property (p_row(8'h53, 8'h53, 2'h3, 3'h4))
    else $error("and direct immediate row wrong");
  a_mov_ind_row: assert property (p_row(8'hA6, 8'hA7, 2'h2, 3'h5))
    else $error("move direct to indirect row wrong");
  a_xwrite_row: assert property (p_row(8'hF2, 8'hF3, 2'h1, 3'h4))
    else $error("external write row wrong");
  a_cjne_reg_row: assert property (p_row(8'hB8, 8'hBF, 2'h3, 3'h4))
    else $error("compare branch register row wrong");

  a_its_reset: assert property (@(posedge core_clk) srst |=> its_field == 3'h1)
    else $error("timing select not two clocks after reset");

  a_sp_preinc: assert property (@(posedge core_clk) disable iff (srst)
    s_push_first |=> sp == $past(sp) + 8'h01 ##[1:60] stack_wr && stack_addr == sp)
    else $error("push did not pre-increment stack pointer");

  a_pc_advance: assert property (@(posedge core_clk) disable iff (srst)
    s_retire |-> pc == $past(pc) + {14'h0000, instr_len})
    else $error("pc did not advance by instruction length");

  a_instr_clocks: assert property (@(posedge core_clk) disable iff (srst)
    last_clk && its_stable |-> clk_cnt == {3'h0, tbl_cyc} * ({3'h0, its_field} + 6'h01))
    else $error("instruction clock count wrong");

endmodule

/* File: logic/cod_op_table.sv */
// Purpose: opcode to byte length and machine-cycle count lookup
// Assumes: load is high for one clock while opcode_in holds a new opcode
// Notes:   outputs are registered and hold until the next load
`timescale 1ns/100ps
`include "cod_regs.svh"

module cod_op_table (
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire logic            load,
  input  wire logic [7:0]      opcode_in,
  output cod_pkg::cod_len_t    tbl_len,
  output cod_pkg::cod_cyc_t    tbl_cyc
);

  logic [4:0] next_entry;

  // length and cycle count per opcode; unlisted codes run as one byte, one cycle
  always_comb begin
    next_entry = {2'h1, 3'h1};
    casez (opcode_in)
      8'b0010_1???, 8'b0110_1???          : next_entry = {2'h1, 3'h1};
      8'h33, 8'h13, 8'b0011_1???          : next_entry = {2'h1, 3'h1};
      8'b1001_1???                        : next_entry = {2'h1, 3'h1};
      8'b0010_011?, 8'b1001_011?          : next_entry = {2'h1, 3'h2};
      8'b0000_1???, 8'b0001_1???, 8'b0011_011?, 8'b0100_011?, 8'b0101_011?,
      8'b0110_011?, 8'b1110_011?, 8'b1100_1???, 8'b1111_1???, 8'h73
                                          : next_entry = {2'h1, 3'h2};
      8'h83, 8'h93                        : next_entry = {2'h1, 3'h3};
      8'b1110_001?, 8'hE0                 : next_entry = {2'h1, 3'h3};
      8'b0000_011?, 8'b0001_011?, 8'b1100_011?, 8'b1101_011?, 8'b1111_011?
                                          : next_entry = {2'h1, 3'h3};
      8'b1111_001?, 8'hF0                 : next_entry = {2'h1, 3'h4};
      8'h22, 8'h32                        : next_entry = {2'h1, 3'h4};
      8'h84, 8'hA4                        : next_entry = {2'h1, 3'h5};
      8'h24, 8'h35, 8'h95, 8'h94          : next_entry = {2'h2, 3'h2};
      8'hB0, 8'hA0, 8'hA2                 : next_entry = {2'h2, 3'h2};
      8'h25, 8'h34, 8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65, 8'h72, 8'h74,
      8'h82, 8'hE5, 8'b0111_1???          : next_entry = {2'h2, 3'h2};
      8'h60, 8'h70, 8'h40, 8'h50          : next_entry = {2'h2, 3'h3};
      8'hD0, 8'h92, 8'b1101_1???          : next_entry = {2'h2, 3'h3};
      8'h05, 8'h15, 8'h42, 8'h52, 8'h62, 8'h80, 8'hB2, 8'hC2, 8'hC5, 8'hD2,
      8'hF5, 8'b1000_1???, 8'b0111_011?, 8'b???0_0001
                                          : next_entry = {2'h2, 3'h3};
      8'b1010_1???, 8'hC0                 : next_entry = {2'h2, 3'h4};
      8'b1000_011?                        : next_entry = {2'h2, 3'h4};
      8'b1010_011?                        : next_entry = {2'h2, 3'h5};
      8'h90                               : next_entry = {2'h3, 3'h3};
      8'h75                               : next_entry = {2'h3, 3'h3};
      8'h53, 8'h10                        : next_entry = {2'h3, 3'h4};
      8'hB5, 8'hB4, 8'b1011_1???, 8'hD5   : next_entry = {2'h3, 3'h4};
      8'h02, 8'h20, 8'h30, 8'h43, 8'h63, 8'h85, 8'b1011_011?
                                          : next_entry = {2'h3, 3'h4};
      8'h12                               : next_entry = {2'h3, 3'h6};
      8'b???1_0001                        : next_entry = {2'h2, 3'h6};
      default                             : next_entry = {2'h1, 3'h1};
    endcase
  end

  // registered read so the table maps onto a small rom
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tbl_len <= 2'h1;
      tbl_cyc <= 3'h1;
    end else if (load) begin
      tbl_len <= next_entry[4:3];
      tbl_cyc <= next_entry[2:0];
    end
  end

endmodule

/* File: logic/cod_pkg.sv */
// Purpose: types of the opcode decode and timing block
// Assumes: nothing
// Notes:   states are Gray coded along boot to run
package cod_pkg;

  typedef enum logic [1:0] {
    COD_BOOT = 2'b00,
    COD_RUN  = 2'b01
  } cod_state_t;

  typedef logic [1:0] cod_len_t;
  typedef logic [2:0] cod_cyc_t;

endpackage

/* File: logic/cod_regs.svh */
// Purpose: shared constants of the opcode decode and timing block
// Assumes: included by bare name from the decode design files
// Notes:   values are counts, reset levels and opcodes, not bus offsets
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

// reset values
`define COD_ITS_RESET   3'h1
`define COD_SP_RESET    8'h07
`define COD_PC_RESET    16'h0000

// opcodes that touch state kept inside this block
`define COD_OP_PUSH     8'hC0
`define COD_OP_POP      8'hD0
`define COD_OP_DPP_LOAD 8'h90

// field widths
`define COD_LEN_W       2
`define COD_CYC_W       3
`define COD_CNT_W       6

`endif

/* File: verification/cod_prog_mem.sv */
// Purpose: program memory model feeding the opcode decode and timing block
// Assumes: asynchronous read, byte at code_addr valid in the same clock
// Notes:   contents are written by the bench before reset is released
`timescale 1ns/100ps

module cod_prog_mem (
  input  wire logic [15:0] code_addr,
  input  wire logic        code_rd,
  output logic      [7:0]  code_data
);
  logic [7:0] mem [0:1023];

  // unselected reads return the inverted byte so a stale value never looks right
  always_comb begin
    if (code_rd) begin
      code_data = (code_addr < 16'h0400) ? mem[code_addr[9:0]] : 8'hFF;
    end else begin
      code_data = ~mem[code_addr[9:0]];
    end
  end
endmodule

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the opcode decode and timing block
// Assumes: design retires instructions back to back, instr_done marks each retire
// Notes:   each pass resets the block and every pass after the first writes the timing select, so a mid-run reset is exercised too
`timescale 1ns/100ps

module testbench;
  localparam int N = 52;
  logic              core_clk;
  logic              srst;
  logic              clk_ctl_wr;
  logic [2:0]        clk_ctl_its;
  logic [7:0]        code_data;
  logic [15:0]       code_addr;
  logic              code_rd;
  logic [7:0]        opcode;
  logic [7:0]        operand1;
  logic [7:0]        operand2;
  cod_pkg::cod_len_t instr_len;
  cod_pkg::cod_cyc_t instr_cycles;
  logic              instr_done;
  logic              mc_end;
  logic [15:0]       pc;
  logic [7:0]        sp;
  logic [15:0]       data_pointer_pair;
  logic              stack_wr;
  logic [7:0]        stack_addr;
  int                bad_count;
  int                checks_done;
  int                n_push;
  logic [7:0]        push_addr;
  logic [15:0]       start [0:N];
  // row = {opcode, byte length, machine cycles}
  logic [15:0]       rows [0:N-1] = '{
    16'h2811, 16'h2F11,
    16'h2612, 16'h2712, 16'h2422,
    16'h3811, 16'h3F11, 16'h3522,
    16'h9811, 16'h9F11, 16'h9522, 16'h9612, 16'h9712, 16'h9422,
    16'h5334,
    16'h6811, 16'h6F11,
    16'h3311, 16'h1311,
    16'hA824, 16'hAF24,
    16'hA625, 16'hA725,
    16'h9033,
    16'h8313, 16'h9313,
    16'hE213, 16'hE313, 16'hE013,
    16'hF214, 16'hF314, 16'hF014,
    16'hC024, 16'hD023,
    16'h6023, 16'h7023,
    16'h4023, 16'h5023,
    16'h1034,
    16'hB534, 16'hB434, 16'hB834, 16'hBF34,
    16'hD823, 16'hDF23, 16'hD534,
    16'hB022, 16'hA022,
    16'h9223, 16'hA222,
    16'h1126,
    16'hA511                                            // unlisted opcode, one byte one cycle
  };

  cod_decode_timing i_dut (
    .core_clk          (core_clk),
    .srst              (srst),
    .code_data         (code_data),
    .code_addr         (code_addr),
    .code_rd           (code_rd),
    .clk_ctl_wr        (clk_ctl_wr),
    .clk_ctl_its       (clk_ctl_its),
    .opcode            (opcode),
    .operand1          (operand1),
    .operand2          (operand2),
    .instr_len         (instr_len),
    .instr_cycles      (instr_cycles),
    .instr_done        (instr_done),
    .mc_end            (mc_end),
    .pc                (pc),
    .sp                (sp),
    .data_pointer_pair (data_pointer_pair),
    .stack_wr          (stack_wr),
    .stack_addr        (stack_addr)
  );

  cod_prog_mem i_mem (
    .code_addr (code_addr),
    .code_rd   (code_rd),
    .code_data (code_data)
  );

  // free running clock, 10 ns period
  always #5 core_clk = ~core_clk;

  // stack writes are sampled on the falling edge to stay clear of the update edge
  always @(negedge core_clk) begin
    if (stack_wr === 1'b1) begin
      n_push++;
      push_addr = stack_addr;
    end
  end

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask

  task automatic end_sim();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // opcodes at their start addresses, operand bytes derived from the address
  task automatic load_prog();
    for (int a = 0; a < 1024; a++) begin
      i_mem.mem[a] = 8'(a) ^ 8'h3C;
    end
    start[0] = 16'h0000;
    for (int i = 0; i < N; i++) begin
      i_mem.mem[start[i]] = rows[i][15:8];
      start[i+1] = start[i] + 16'(rows[i][7:4]);
    end
    for (int a = int'(start[N]); a < 1024; a++) begin
      i_mem.mem[a] = 8'h00;
    end
  endtask

  task automatic run_pass(input logic [2:0] its, input logic wr);
    int clks;
    int mcs;
    int cyc;
    @(posedge core_clk);
    srst       <= 1'b1;
    clk_ctl_wr <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    n_push = 0;
    check(sp === 8'h07 && stack_addr === 8'h07 && pc === 16'h0000, "reset pointers");
    check(instr_len === 2'h1 && instr_cycles === 3'h1 && code_rd === 1'b0, "reset fields");
    check(opcode === 8'h00 && data_pointer_pair === 16'h0000 && stack_wr === 1'b0, "reset outputs");
    @(posedge core_clk);
    srst        <= 1'b0;
    clk_ctl_wr  <= wr;
    clk_ctl_its <= its;
    @(posedge core_clk);
    clk_ctl_wr <= 1'b0;
    #1;
    check(code_rd === 1'b1 && instr_done === 1'b0, "fetch start after reset");
    // walk the table: each retire is compared with its row
    for (int i = 0; i < N; i++) begin
      clks = 0;
      mcs  = 0;
      cyc  = int'(rows[i][3:0]);
      do begin
        @(posedge core_clk);
        #1;
        clks++;
        if (mc_end === 1'b1) mcs++;
      end while (instr_done !== 1'b1 && clks < 200);
      check(clks < 200, "instruction never retired");
      check(instr_len === rows[i][5:4] && instr_cycles === rows[i][2:0], "length or cycles");
      check(pc === start[i+1], "pc advance");
      check(opcode === i_mem.mem[start[i+1]] && code_addr === start[i+1] + 16'h0001, "next fetch");
      if (rows[i][7:4] >= 4'h2) begin
        check(operand1 === i_mem.mem[start[i] + 16'h0001], "first operand");
      end
      if (rows[i][7:4] == 4'h3) begin
        check(operand2 === i_mem.mem[start[i] + 16'h0002], "second operand");
      end
      if (i > 0) begin
        check(clks == cyc * (int'(its) + 1), "instruction clocks");
        check(mcs == cyc, "machine cycle count");
      end
      if (rows[i][15:8] == 8'h90) begin
        check(data_pointer_pair === {i_mem.mem[start[i]+1], i_mem.mem[start[i]+2]}, "pointer load");
      end
      if (rows[i][15:8] == 8'hC0) begin
        check(sp === 8'h08, "sp after push");
      end
      if (rows[i][15:8] == 8'hD0) begin
        check(sp === 8'h07, "sp after pop");
      end
    end
    check(n_push == 1 && push_addr === 8'h08, "first push slot");
  endtask

  // watchdog, far beyond the few thousand clocks the passes need
  initial begin
    #400000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end

  // default 2T first, then 1T, 8T and 4T after fresh resets
  initial begin
    core_clk    = 1'b0;
    srst        = 1'b1;
    clk_ctl_wr  = 1'b0;
    clk_ctl_its = 3'h0;
    bad_count   = 0;
    checks_done = 0;
    n_push      = 0;
    push_addr   = 8'h00;
    load_prog();
    run_pass(3'h1, 1'b0);
    run_pass(3'h0, 1'b1);
    run_pass(3'h7, 1'b1);
    run_pass(3'h3, 1'b1);
    end_sim();
  end
endmodule
